// [rtl/gcw_params.svh]
/*
  Constants for the gateway watchdog and status block: offsets, fields,
  reset values and timing counts. Assumes a 200 MHz mclk.
*/
// How it works
// [RQ1] Watchdog interval setting counts 100 ms units; N means N tenths.
// [RQ2] Interval setting of zero disables the watchdog completely.
// [RQ3] No client traffic within the interval expires timer and forces reset.
// [RQ4] After any reset the interval defaults to 100 tenths, ten seconds.
// [RQ5] Set-interval applies at once and restarts the timer from the new interval.
// [RQ6] Interlock request returns a byte, bit n one when channel n powered.
// [RQ7] Up to six interlock channels, each sensed by its own input.
// [RQ8] The block keeps its own active port record without client requests.
// [RQ9] Link request returns a 16-bit snapshot, bit n set when port connected.
// [RQ10] Status holds only a reset-occurred flag; no comm-fault or type flags.
// [RQ11] Set reset flag reports restart error with gateway id in low byte.
// [RQ12] Client addresses the gateway with port number 0xFF.
// [RQ13] No-operation changes nothing but returns the module status.
// [RQ14] Each valid client communication restarts the timer from full interval.
// [RQ15] After any hardware reset the reset-occurred flag stays set until cleared.
`ifndef GCW_PARAMS_SVH
`define GCW_PARAMS_SVH

`define GCW_CLK_HZ         200000000
`define GCW_TICK_MS        100
`define GCW_TICK_CYC       ((`GCW_CLK_HZ / 1000) * `GCW_TICK_MS)
`define GCW_DEF_TENTHS     8'h64
`define GCW_GATEWAY_PORT   8'hFF

`define GCW_ADDR_CTRL      4'h0
`define GCW_ADDR_STATUS    4'h1
`define GCW_ADDR_INTERLOCK 4'h2
`define GCW_ADDR_LINK      4'h3
`define GCW_ADDR_IRQ_STAT  4'h4
`define GCW_ADDR_IRQ_MASK  4'h5
`define GCW_ADDR_ERROR     4'h6

`define GCW_STAT_RST_BIT   0
`define GCW_IRQ_RST_BIT    0
`define GCW_IRQ_LINK_BIT   1
`define GCW_IRQ_LOCK_BIT   2

`endif

// [rtl/gcw_pkg.sv]
/*
  Types for the gateway watchdog and status block.
  Assumes gcw_params.svh is included by the design file.
*/
package gcw_pkg;

  typedef enum logic [2:0] {
    GCW_ACT_NONE      = 3'b000,
    GCW_ACT_NOP       = 3'b001,
    GCW_ACT_SETWD     = 3'b010,
    GCW_ACT_INTERLOCK = 3'b011,
    GCW_ACT_LINK      = 3'b100,
    GCW_ACT_CLEAR     = 3'b101
  } gcw_action_type;

  typedef struct packed {
    logic           valid;
    gcw_action_type action;
    logic [7:0]     port;
    logic [7:0]     arg;
  } gcw_req_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic [7:0]  status;
    logic [31:0] error;
  } gcw_rsp_type;

  typedef struct packed {
    logic [7:0]  tenths_r;
    logic [7:0]  tenths_left_r;
    logic [31:0] tick_cnt_r;
    logic        rst_flag_r;
    logic        wd_reset_r;
    logic [5:0]  lock_r;
    logic [15:0] ports_r;
    logic [2:0]  irq_stat_r;
    logic [2:0]  irq_mask_r;
    logic        irq_r;
    logic [15:0] rdata_r;
    gcw_rsp_type rsp_r;
  } gcw_state_type;

endpackage

// [rtl/gcw_watchdog.sv]
/*
  Gateway communication watchdog with interlock and link status.
  Assumes interlock sense inputs are asynchronous pins and that the port
  presence inputs come from link logic on mclk. The external reset
  controller feeds wd_reset_req back into rstn.
*/
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "gcw_params.svh"

module gcw_watchdog
  import gcw_pkg::*;
#(
  parameter int          NUM_LOCKS = 6,
  parameter int          NUM_PORTS = 16,
  parameter logic [31:0] TICK_CYC  = `GCW_TICK_CYC,
  parameter logic [7:0]  MODULE_ID = 8'h5A  // Arbitrary value
)
(
  input  wire logic           mclk,
  input  wire logic           rstn,
  input  wire gcw_req_type    req,
  output      gcw_rsp_type    rsp,
  input  wire logic [5:0]     interlock_sense,
  input  wire logic [15:0]    port_present,
  input  wire logic [3:0]     reg_addr,
  input  wire logic [15:0]    reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output      logic [15:0]    reg_rdata,
  output      logic           wd_reset_req,
  output      logic           irq
);

  gcw_state_type s_r;
  gcw_state_type s_nxt;
  logic [5:0]    lock_meta_r;
  logic [5:0]    lock_sync_r;
  logic          wd_enabled;
  logic          wd_expire;
  logic          client_kick;
  logic          set_wd;
  logic          gw_target;
  logic [2:0]    irq_events;

  // [RQ7] Sense sync
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      lock_meta_r <= 6'h00;
      lock_sync_r <= 6'h00;
    end
    else
    begin
      lock_meta_r <= interlock_sense;
      lock_sync_r <= lock_meta_r;
    end
  end

  // [RQ12] Gateway addressing
  assign gw_target   = req.port == `GCW_GATEWAY_PORT;
  assign client_kick = req.valid && req.action != GCW_ACT_NONE;
  assign set_wd      = client_kick && gw_target && req.action == GCW_ACT_SETWD;
  // [RQ2] Zero disables
  assign wd_enabled  = s_r.tenths_r != 8'h00;
  assign wd_expire   = wd_enabled && s_r.tenths_left_r == 8'h01 && s_r.tick_cnt_r == TICK_CYC - 32'h1;

  always_comb
  begin
    s_nxt = s_r;
    irq_events = 3'b000;
    s_nxt.rsp_r.valid = 1'b0;
    s_nxt.rdata_r = 16'h0000;
    s_nxt.lock_r = lock_sync_r;
    // [RQ8] Own port record
    s_nxt.ports_r = port_present;
    if (s_nxt.ports_r != s_r.ports_r)
      irq_events[`GCW_IRQ_LINK_BIT] = 1'b1;
    if (s_nxt.lock_r != s_r.lock_r)
      irq_events[`GCW_IRQ_LOCK_BIT] = 1'b1;

    // [RQ1] Tenths counting
    if (wd_enabled)
    begin
      if (s_r.tick_cnt_r == TICK_CYC - 32'h1)
      begin
        s_nxt.tick_cnt_r = 32'h0;
        s_nxt.tenths_left_r = s_r.tenths_left_r - 8'h01;
      end
      else
        s_nxt.tick_cnt_r = s_r.tick_cnt_r + 32'h1;
    end
    // [RQ3] Expiry resets
    if (wd_expire)
      s_nxt.wd_reset_r = 1'b1;

    // [RQ14] Client kick
    if (client_kick)
    begin
      s_nxt.tick_cnt_r = 32'h0;
      s_nxt.tenths_left_r = s_r.tenths_r;
    end
    // [RQ5] New interval now
    if (set_wd)
    begin
      s_nxt.tenths_r = req.arg;
      s_nxt.tenths_left_r = req.arg;
    end

    if (client_kick && gw_target)
    begin
      s_nxt.rsp_r.valid = 1'b1;
      s_nxt.rsp_r.data = 16'h0000;
      unique case (req.action)
        // [RQ6] Interlock byte
        GCW_ACT_INTERLOCK: s_nxt.rsp_r.data = {10'h000, s_r.lock_r};
        // [RQ9] Link snapshot
        GCW_ACT_LINK:      s_nxt.rsp_r.data = s_r.ports_r;
        GCW_ACT_CLEAR:     if (req.arg[`GCW_STAT_RST_BIT]) s_nxt.rst_flag_r = 1'b0;
        // [RQ13] Status only
        GCW_ACT_NOP:       s_nxt.rsp_r.data = 16'h0000;
        default:           s_nxt.rsp_r.data = 16'h0000;
      endcase
      // [RQ10] Reset flag only
      s_nxt.rsp_r.status = {7'h00, s_r.rst_flag_r};
      // [RQ11] Restart error code
      s_nxt.rsp_r.error = s_r.rst_flag_r ? {16'h0000, 8'h01, MODULE_ID} : 32'h0;
    end

    s_nxt.irq_stat_r = s_r.irq_stat_r | irq_events;
    if (reg_wr)
    begin
      unique case (reg_addr)
        `GCW_ADDR_CTRL:
        begin
          s_nxt.tenths_r = reg_wdata[7:0];
          s_nxt.tenths_left_r = reg_wdata[7:0];
          s_nxt.tick_cnt_r = 32'h0;
        end
        `GCW_ADDR_STATUS:
          if (reg_wdata[`GCW_STAT_RST_BIT]) s_nxt.rst_flag_r = 1'b0;
        // Set beats clear so no event is lost
        `GCW_ADDR_IRQ_STAT: s_nxt.irq_stat_r = (s_r.irq_stat_r & ~reg_wdata[2:0]) | irq_events;
        `GCW_ADDR_IRQ_MASK: s_nxt.irq_mask_r = reg_wdata[2:0];
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        `GCW_ADDR_CTRL:      s_nxt.rdata_r = {8'h00, s_r.tenths_r};
        `GCW_ADDR_STATUS:    s_nxt.rdata_r = {15'h0000, s_r.rst_flag_r};
        `GCW_ADDR_INTERLOCK: s_nxt.rdata_r = {10'h000, s_r.lock_r};
        `GCW_ADDR_LINK:      s_nxt.rdata_r = s_r.ports_r;
        `GCW_ADDR_IRQ_STAT:  s_nxt.rdata_r = {13'h0000, s_r.irq_stat_r};
        `GCW_ADDR_IRQ_MASK:  s_nxt.rdata_r = {13'h0000, s_r.irq_mask_r};
        `GCW_ADDR_ERROR:     s_nxt.rdata_r = s_r.rst_flag_r ? {8'h01, MODULE_ID} : 16'h0000;
        default:             s_nxt.rdata_r = 16'h0000;
      endcase
    end
    s_nxt.irq_r = |(s_nxt.irq_stat_r & s_nxt.irq_mask_r);
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r <= '0;
      // [RQ4] Default interval
      s_r.tenths_r <= `GCW_DEF_TENTHS;
      s_r.tenths_left_r <= `GCW_DEF_TENTHS;
      // [RQ15] Flag after reset
      s_r.rst_flag_r <= 1'b1;
      s_r.irq_stat_r <= 3'b001;
    end
    else
      s_r <= s_nxt;
  end

  assign rsp          = s_r.rsp_r;
  assign reg_rdata    = s_r.rdata_r;
  assign wd_reset_req = s_r.wd_reset_r;
  assign irq          = s_r.irq_r;

  a_zero_disables: assert property (@(posedge mclk) disable iff (!rstn)
    s_r.tenths_r == 8'h00 |=> !wd_reset_req) else $error("watchdog fired while disabled"); // [RQ2]
  a_expiry_reset: assert property (@(posedge mclk) disable iff (!rstn)
    wd_expire |=> wd_reset_req) else $error("expiry without reset"); // [RQ3]
  a_setwd_apply: assert property (@(posedge mclk) disable iff (!rstn)
    set_wd |=> s_r.tenths_r == $past(req.arg) && s_r.tenths_left_r == $past(req.arg)) else $error("interval not applied"); // [RQ5]
  a_kick_restart: assert property (@(posedge mclk) disable iff (!rstn)
    client_kick && !set_wd && !reg_wr |=> s_r.tick_cnt_r == 32'h0 && s_r.tenths_left_r == $past(s_r.tenths_r)) else $error("kick no restart"); // [RQ14]
  a_lock_reply: assert property (@(posedge mclk) disable iff (!rstn)
    client_kick && gw_target && req.action == GCW_ACT_INTERLOCK |=> rsp.valid && rsp.data[15:6] == 10'h000) else $error("bad interlock reply"); // [RQ6]
  a_link_reply: assert property (@(posedge mclk) disable iff (!rstn)
    client_kick && gw_target && req.action == GCW_ACT_LINK |=> rsp.data == $past(s_r.ports_r)) else $error("bad link reply"); // [RQ9]
  a_status_only: assert property (@(posedge mclk) disable iff (!rstn)
    rsp.valid |-> rsp.status[7:1] == 7'h00) else $error("extra status bits"); // [RQ10]
  a_error_id: assert property (@(posedge mclk) disable iff (!rstn)
    rsp.valid && rsp.status[0] |-> rsp.error[7:0] == MODULE_ID) else $error("error lacks id"); // [RQ11]
  a_nop_status: assert property (@(posedge mclk) disable iff (!rstn)
    client_kick && gw_target && req.action == GCW_ACT_NOP |=> rsp.valid ##0 $stable(s_r.rst_flag_r)) else $error("nop bad"); // [RQ13]
  a_ports_track: assert property (@(posedge mclk) disable iff (!rstn)
    1'b1 |=> s_r.ports_r == $past(port_present)) else $error("port record stale"); // [RQ8]

  // Interlock sense path, reply contents and change flags, plus the link change flag
  a_lock_sync: assert property (@(posedge mclk) disable iff (!rstn) // [RQ7]
    1'b1 |=> lock_sync_r == $past(lock_meta_r))
    else $error("sense sync skipped a stage");

  a_lock_track: assert property (@(posedge mclk) disable iff (!rstn) // [RQ7]
    1'b1 |=> s_r.lock_r == $past(lock_sync_r))
    else $error("interlock record stale");

  a_lock_data: assert property (@(posedge mclk) disable iff (!rstn) // [RQ6]
    client_kick && gw_target && req.action == GCW_ACT_INTERLOCK |=> rsp.data[5:0] == $past(s_r.lock_r))
    else $error("interlock reply wrong bits");

  a_lock_irq: assert property (@(posedge mclk) disable iff (!rstn) // [RQ7]
    s_r.lock_r != lock_sync_r |=> s_r.irq_stat_r[`GCW_IRQ_LOCK_BIT])
    else $error("interlock change not flagged");

  a_irq_link: assert property (@(posedge mclk) disable iff (!rstn) // [RQ8]
    s_r.ports_r != port_present |=> s_r.irq_stat_r[`GCW_IRQ_LINK_BIT])
    else $error("link change not flagged");

  // Interval timing: one tick per cycle, one tenth per full tick span
  a_tick_step: assert property (@(posedge mclk) disable iff (!rstn) // [RQ1]
    wd_enabled && !client_kick && !reg_wr && s_r.tick_cnt_r != TICK_CYC - 32'h1
    |=> s_r.tick_cnt_r == $past(s_r.tick_cnt_r) + 32'h1)
    else $error("tick counter did not advance");

  a_tenth_step: assert property (@(posedge mclk) disable iff (!rstn) // [RQ1]
    wd_enabled && !client_kick && !reg_wr && s_r.tick_cnt_r == TICK_CYC - 32'h1
    |=> s_r.tenths_left_r == $past(s_r.tenths_left_r) - 8'h01)
    else $error("tenths count did not step");

  a_zero_frozen: assert property (@(posedge mclk) disable iff (!rstn) // [RQ2]
    !wd_enabled && !client_kick && !reg_wr |=> $stable(s_r.tick_cnt_r))
    else $error("timer ran while disabled");

  a_no_expire_off: assert property (@(posedge mclk) disable iff (!rstn) // [RQ2]
    !wd_enabled |-> !wd_expire)
    else $error("expiry while disabled");

  // Reset request stays up until the external controller acts
  a_reset_sticky: assert property (@(posedge mclk) disable iff (!rstn) // [RQ3]
    wd_reset_req |=> wd_reset_req)
    else $error("reset request dropped");

  a_no_early_reset: assert property (@(posedge mclk) disable iff (!rstn) // [RQ3]
    !wd_expire && !wd_reset_req |=> !wd_reset_req)
    else $error("reset request without expiry");

  // Restart sources and gateway addressing
  a_other_port_kick: assert property (@(posedge mclk) disable iff (!rstn) // [RQ14]
    client_kick && !gw_target && !reg_wr
    |=> s_r.tick_cnt_r == 32'h0 && s_r.tenths_left_r == $past(s_r.tenths_r))
    else $error("module traffic did not restart timer");

  a_ctrl_write: assert property (@(posedge mclk) disable iff (!rstn) // [RQ5]
    reg_wr && reg_addr == `GCW_ADDR_CTRL |=> s_r.tenths_r == $past(reg_wdata[7:0]) && s_r.tick_cnt_r == 32'h0)
    else $error("interval write not applied");

  a_rsp_gateway: assert property (@(posedge mclk) disable iff (!rstn) // [RQ12]
    !(client_kick && gw_target) |=> !rsp.valid)
    else $error("reply for a non-gateway port");

  // Reset-occurred flag: only reset sets it, only a clear drops it
  a_flag_stays: assert property (@(posedge mclk) disable iff (!rstn) // [RQ15]
    s_r.rst_flag_r && !(reg_wr && reg_addr == `GCW_ADDR_STATUS)
    && !(client_kick && gw_target && req.action == GCW_ACT_CLEAR) |=> s_r.rst_flag_r)
    else $error("reset flag lost");

  a_flag_no_set: assert property (@(posedge mclk) disable iff (!rstn) // [RQ15]
    !s_r.rst_flag_r |=> !s_r.rst_flag_r)
    else $error("reset flag set without reset");

  a_clear_flag: assert property (@(posedge mclk) disable iff (!rstn) // [RQ15]
    client_kick && gw_target && req.action == GCW_ACT_CLEAR && req.arg[0] |=> !s_r.rst_flag_r)
    else $error("clear action ignored");

  a_rd_status: assert property (@(posedge mclk) disable iff (!rstn) // [RQ15]
    reg_rd && reg_addr == `GCW_ADDR_STATUS |=> reg_rdata == {15'h0000, $past(s_r.rst_flag_r)})
    else $error("status read wrong");

  // Error word and no-operation replies
  a_error_zero: assert property (@(posedge mclk) disable iff (!rstn) // [RQ11]
    rsp.valid && !rsp.status[0] |-> rsp.error == 32'h0)
    else $error("error without reset flag");

  a_error_code: assert property (@(posedge mclk) disable iff (!rstn) // [RQ11]
    rsp.valid && rsp.status[0] |-> rsp.error[31:8] == 24'h000001)
    else $error("wrong restart error code");

  a_nop_data: assert property (@(posedge mclk) disable iff (!rstn) // [RQ13]
    client_kick && gw_target && req.action == GCW_ACT_NOP |=> rsp.data == 16'h0000)
    else $error("nop returned data");

  a_nop_keeps: assert property (@(posedge mclk) disable iff (!rstn) // [RQ13]
    client_kick && gw_target && req.action == GCW_ACT_NOP && !reg_wr |=> $stable(s_r.tenths_r))
    else $error("nop changed interval");

  // Register port and interrupt output
  a_rdata_idle: assert property (@(posedge mclk) disable iff (!rstn)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");

  a_irq_level: assert property (@(posedge mclk) disable iff (!rstn)
    irq == |(s_r.irq_stat_r & s_r.irq_mask_r))
    else $error("irq level mismatch");

  c_expire:   cover property (@(posedge mclk) disable iff (!rstn) wd_expire);
  c_setwd:    cover property (@(posedge mclk) disable iff (!rstn) set_wd);
  c_link:     cover property (@(posedge mclk) disable iff (!rstn) rsp.valid && rsp.data != 16'h0000);
  c_irq:      cover property (@(posedge mclk) disable iff (!rstn) irq);
  c_clear:    cover property (@(posedge mclk) disable iff (!rstn) rsp.valid && !rsp.status[0]);

endmodule

// [tb/gcw_client.sv]
/*
  Client model: issues gateway actions one at a time.
  Assumes the bench calls send() from a single process.
*/
`timescale 1ns/1ps
module gcw_client
  import gcw_pkg::*;
(
  input  wire logic        mclk,
  output      gcw_req_type req
);
  initial req = '0;

  // caller picks the port
  // Idle fields are scrambled so a stale value never looks like a request
  task automatic send(input gcw_action_type a, input logic [7:0] p, input logic [7:0] d);
    @(posedge mclk);
    req <= '{1'h1, a, p, d};
    @(posedge mclk);
    req <= '{1'h0, GCW_ACT_NONE, ~p, ~d};
    #1;
  endtask
endmodule

// [tb/tb_top.sv]
/*
  Self-checking bench for the gateway watchdog block.
  Assumes a short tick parameter so interval counts stay small.
*/
`timescale 1ns/1ps
`include "gcw_params.svh"
module tb_top
  import gcw_pkg::*;
;
  localparam logic [31:0] TK = 32'h0000000A;
  logic        mclk  = 1'h0;
  logic        rstn  = 1'h0;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic [5:0]  sense = 6'h00;
  logic [15:0] ports = 16'h0000;
  logic [3:0]  addr  = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] rd;
  logic        wd_reset_req;
  logic        irq;
  gcw_req_type req;
  gcw_rsp_type rsp;
  int          errors = 0;
  int          n_compared = 0;
  int          seed = 32'hFDA4;
  int          exp_flag;
  int          exp_tenths;
  int          n;

  always #2.5 mclk = ~mclk;

  gcw_client CL (.mclk(mclk), .req(req));

  gcw_watchdog #(.TICK_CYC(TK)) DUT (
    .mclk(mclk), .rstn(rstn), .req(req), .rsp(rsp), .interlock_sense(sense), .port_present(ports),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .wd_reset_req(wd_reset_req), .irq(irq));

  task automatic test_done;
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic regw(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask

  task automatic regr(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 d = rdata;
  endtask

  // Reset pulse as the external controller would give it
  task automatic pulse_reset;
    @(posedge mclk);
    rstn <= 1'h0;
    repeat (6) @(posedge mclk);
    rstn <= 1'h1;
    exp_flag = 1;
    exp_tenths = 100;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    test_done();
  end

  initial
  begin
    repeat (6) @(posedge mclk);
    rstn <= 1'h1;
    exp_flag = 1;
    exp_tenths = 100;
    regr(`GCW_ADDR_CTRL, rd); chk("interval", exp_tenths, rd);
    regr(`GCW_ADDR_STATUS, rd); chk("status reg", exp_flag, rd);
    regr(4'hF, rd); chk("unmapped", 0, rd);
    CL.send(GCW_ACT_NOP, 8'hFF, 8'h00); chk("nop valid", 1, rsp.valid);
    chk("nop status", exp_flag, rsp.status);
    chk("restart error", {16'h0000, 8'h01, 8'h5A}, rsp.error);
    regw(`GCW_ADDR_IRQ_MASK, 16'h0007);
    repeat (2) @(posedge mclk);
    #1 chk("irq set", 1, irq);
    regw(`GCW_ADDR_IRQ_STAT, 16'h0007);
    repeat (2) @(posedge mclk);
    #1 chk("irq clear", 0, irq);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      sense <= $random(seed);
      ports <= $random(seed);
      repeat (4) @(posedge mclk);
      CL.send(GCW_ACT_INTERLOCK, 8'hFF, 8'h00); chk("interlock", {10'h000, sense}, rsp.data);
      CL.send(GCW_ACT_LINK, 8'hFF, 8'h00); chk("links", ports, rsp.data);
    end
    chk("irq event", 1, irq);
    CL.send(GCW_ACT_CLEAR, 8'hFF, 8'h01);
    exp_flag = 0;
    CL.send(GCW_ACT_NOP, 8'hFF, 8'h00); chk("cleared status", exp_flag, rsp.status);
    chk("no error", 0, rsp.error);
    // Short interval so expiry lands inside the run
    CL.send(GCW_ACT_SETWD, 8'hFF, 8'h02);
    exp_tenths = 2;
    regr(`GCW_ADDR_CTRL, rd); chk("new interval", exp_tenths, rd);
    for (int i = 0; i < 5; i++)
    begin
      repeat (exp_tenths * TK - 8) @(posedge mclk);
      CL.send(GCW_ACT_NOP, 8'h03, 8'h00);
    end
    chk("kept alive", 0, wd_reset_req);
    n = 0;
    while (wd_reset_req !== 1'h1 && n < 40)
    begin
      @(posedge mclk);
      #1 n++;
    end
    chk("expiry time", 1, n >= 17 && n <= 22);
    pulse_reset();
    regr(`GCW_ADDR_STATUS, rd); chk("flag after wd", exp_flag, rd);
    regr(`GCW_ADDR_CTRL, rd); chk("default again", exp_tenths, rd);
    CL.send(GCW_ACT_SETWD, 8'hFF, 8'h00);
    repeat (3000) @(posedge mclk);
    #1 chk("disabled", 0, wd_reset_req);
    test_done();
  end
endmodule
